// file: shared/timer_core_if.sv
// carrier between the register side and one counting core
// assumes both ends run on the same clock and reset
`default_nettype none

interface timer_core_if;
	logic                    enable;
	timer_pkg::mode_t        mode;
	logic                    polarity;
	logic [2:0]              prescale;
	timer_pkg::count_t       reload;
	timer_pkg::count_t       match;
	logic                    cnt_wr;
	timer_pkg::count_t       cnt_wdata;
	logic                    in_sync;
	timer_pkg::count_t       count;
	logic                    pwm;
	logic                    reload_evt;
	logic                    compare_evt;
	logic                    capture_evt;
	logic                    oneshot_done;

	modport ctrl (output enable, mode, polarity, prescale, reload, match, cnt_wr, cnt_wdata,
		in_sync, input count, pwm, reload_evt, compare_evt, capture_evt, oneshot_done);
	modport core (input enable, mode, polarity, prescale, reload, match, cnt_wr, cnt_wdata,
		in_sync, output count, pwm, reload_evt, compare_evt, capture_evt, oneshot_done);
endinterface

`default_nettype wire

// file: shared/timer_params.svh
// offsets, field positions, reset values and mode codes of the timer block
// assumes inclusion by the design and bench files under one include path
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// register indices: byte address is four times the index
`define IDX_T0_MATCH_L   12'hF05
`define IDX_T0_CTL0      12'hF06
`define IDX_T1_MATCH_L   12'hF0D
`define IDX_T1_CTL0      12'hF0E
// index group (index bits 11:3) of each timer
`define GRP_T0           9'h1E0
`define GRP_T1           9'h1E1
// register within a group (index bits 2:0)
`define REG_CNT_H        3'h0
`define REG_CNT_L        3'h1
`define REG_RLD_H        3'h2
`define REG_RLD_L        3'h3
`define REG_MATCH_H      3'h4
`define REG_MATCH_L      3'h5
`define REG_CTL0         3'h6
`define REG_CTL1         3'h7

// control zero fields
`define CTL0_MODE_MSB    7
`define CTL0_CFG_HI      6
`define CTL0_CFG_LO      5
`define CTL0_DB_HI       3
`define CTL0_DB_LO       1
`define CTL0_FLAG        0
`define CTL0_WMASK       8'hEF
// control one fields
`define CTL1_RUN         7
`define CTL1_POL         6
`define CTL1_PRES_HI     5
`define CTL1_PRES_LO     3
`define CTL1_MODE_HI     2

`define REG_RESET        8'h00
`define CNT_RESTART      16'h0001

// timer mode codes
`define MODE_ONESHOT     4'h0
`define MODE_PWM_SINGLE  4'h3
`define MODE_CAPTURE     4'h4
`define MODE_CAPCMP      4'h7
`define MODE_PWM_DUAL    4'h8

`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`define DB_CNT_MAX       8'hFF

`endif

// file: shared/timer_pkg.sv
// types shared by the timer block files
// assumes timer_params.svh is reachable on the include path
`default_nettype none

package timer_pkg;
	typedef logic [15:0] count_t;
	typedef logic [3:0]  mode_t;
	typedef logic [7:0]  reg_byte_t;
endpackage

`default_nettype wire

// file: src/timer_core.sv
// one 16-bit counting core: prescaler, reload, pwm level, input capture
// assumes a synchronised input and a synchronous reset copy from the top
`include "timer_params.svh"
`default_nettype none

module timer_core (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// register side
	timer_core_if.core       cif
);
	logic [6:0] presc_q;
	logic [6:0] presc_last;
	logic       tick;
	logic       at_reload;
	logic       is_pwm;
	logic       is_cap;
	logic       in_prev_q;
	logic       edge_seen;

	assign presc_last = 7'((8'h01 << cif.prescale) - 8'h01);
	assign tick       = cif.enable && (presc_q == presc_last);
	assign at_reload  = (cif.count == cif.reload);
	assign is_pwm     = (cif.mode == `MODE_PWM_SINGLE) || (cif.mode == `MODE_PWM_DUAL);
	assign is_cap     = (cif.mode == `MODE_CAPTURE) || (cif.mode == `MODE_CAPCMP);

	// ==========================================================
	// prescaler
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			presc_q <= 7'h00;
		end else if (!cif.enable || tick) begin
			presc_q <= 7'h00;
		end else begin
			presc_q <= presc_q + 7'h01;
		end
	end

	// ==========================================================
	// counter
	// loaded start count only shapes the first pass, then 1 to reload
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cif.count <= 16'h0000;
		end else if (cif.cnt_wr) begin
			cif.count <= cif.cnt_wdata;
		end else if (tick) begin
			if (at_reload) begin
				cif.count <= `CNT_RESTART;
			end else begin
				cif.count <= cif.count + 16'h0001;
			end
		end
	end

	assign cif.reload_evt   = tick && at_reload;
	assign cif.compare_evt  = tick && is_pwm && (cif.count == cif.match);
	assign cif.oneshot_done = cif.reload_evt && (cif.mode == `MODE_ONESHOT);

	// ==========================================================
	// pwm level: polarity at period start, flipped at the match
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cif.pwm <= 1'b0;
		end else if (!cif.enable || !is_pwm || cif.reload_evt) begin
			cif.pwm <= cif.polarity;
		end else if (cif.compare_evt) begin
			cif.pwm <= ~cif.polarity;
		end
	end

	// ==========================================================
	// capture edge
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			in_prev_q <= 1'b0;
		end else begin
			in_prev_q <= cif.in_sync;
		end
	end

	// polarity 0 takes rising edges, 1 takes falling edges
	assign edge_seen = cif.polarity ? (in_prev_q && !cif.in_sync)
	                                : (!in_prev_q && cif.in_sync);
	assign cif.capture_evt = cif.enable && is_cap && edge_seen;

	// ==========================================================
	// checks
	AST_RESTART_AT_ONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		cif.reload_evt && !cif.cnt_wr |=> cif.count == `CNT_RESTART)
		else $error("count did not restart at one after reload");
	AST_FIRST_PASS_UP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		tick && !at_reload && !cif.cnt_wr |=> cif.count == $past(cif.count) + 16'h0001)
		else $error("count did not step toward reload");
	AST_PERIOD_START_LEVEL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		cif.reload_evt && is_pwm |=> cif.pwm == $past(cif.polarity))
		else $error("pwm level wrong at period start");
	AST_MATCH_FLIP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		cif.compare_evt && !cif.reload_evt |=> cif.pwm == !$past(cif.polarity))
		else $error("pwm did not change at match");
	AST_CAPTURE_EDGE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		cif.capture_evt |-> (cif.in_sync != cif.polarity) && (in_prev_q == cif.polarity))
		else $error("capture on wrong edge");
	AST_HOLD_WHEN_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!cif.enable && !cif.cnt_wr |=> $stable(cif.count))
		else $error("count moved while disabled");
	AST_TICK_SPACING: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		tick && cif.prescale == 3'h1 && cif.enable |=> !tick ##1 (tick || !cif.enable))
		else $error("prescale by two not kept");

	COV_PWM_RELOAD: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		cif.reload_evt && is_pwm);
	COV_CAPTURE: cover property (@(posedge clk_i) disable iff (!rst_n_i) cif.capture_evt);
endmodule

`default_nettype wire

// file: src/timer_pwm_capture_core.sv
// two 16-bit timers with pwm, dead band, capture; AXI4-Lite register slave
// assumes a 10 MHz ref_clk_i and an asynchronous active-low reset input
//
// Register access over AXI4-Lite was chosen for this implementation.
`include "timer_params.svh"
`default_nettype none

module timer_pwm_capture_core (
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        resetn_i,
	// axi4-lite write address
	input  wire logic [15:0] awaddr_i,
	input  wire logic        awvalid_i,
	output logic             awready_o,
	// axi4-lite write data
	input  wire logic [31:0] wdata_i,
	input  wire logic [3:0]  wstrb_i,
	input  wire logic        wvalid_i,
	output logic             wready_o,
	// axi4-lite write response
	output logic [1:0]       bresp_o,
	output logic             bvalid_o,
	input  wire logic        bready_i,
	// axi4-lite read
	input  wire logic [15:0] araddr_i,
	input  wire logic        arvalid_i,
	output logic             arready_o,
	output logic [31:0]      rdata_o,
	output logic [1:0]       rresp_o,
	output logic             rvalid_o,
	input  wire logic        rready_i,
	// timer pins, one bit per timer
	output logic [1:0]       tmr_out_o,
	input  wire logic [1:0]  tmr_in_i,
	output logic [1:0]       tmr_comp_o,
	output logic [1:0]       tmr_comp_oe_o,
	output logic [1:0]       tmr_event_o
);
	// ==========================================================
	// reset release
	logic [1:0] rst_sync_q;
	logic       rst_n;

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ==========================================================
	// write channel
	logic        aw_hold_q;
	logic [15:0] aw_addr_q;
	logic        w_hold_q;
	logic [7:0]  w_byte_q;
	logic        w_lane_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        do_wr;
	logic        wr_en;
	logic [1:0]  wr_hit;
	logic [2:0]  wr_reg;

	assign awready_o = !aw_hold_q && !bvalid_q;
	assign wready_o  = !w_hold_q && !bvalid_q;
	assign do_wr     = aw_hold_q && w_hold_q && !bvalid_q;
	assign wr_en     = do_wr && w_lane_q;
	assign wr_reg    = aw_addr_q[4:2];
	assign bvalid_o  = bvalid_q;
	assign bresp_o   = bresp_q;

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			aw_hold_q <= 1'b0;
			aw_addr_q <= 16'h0000;
		end else if (awvalid_i && awready_o) begin
			aw_hold_q <= 1'b1;
			aw_addr_q <= awaddr_i;
		end else if (do_wr) begin
			aw_hold_q <= 1'b0;
		end
	end

	// registers are one byte wide; only lane 0 carries them
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			w_hold_q <= 1'b0;
			w_byte_q <= 8'h00;
			w_lane_q <= 1'b0;
		end else if (wvalid_i && wready_o) begin
			w_hold_q <= 1'b1;
			w_byte_q <= wdata_i[7:0];
			w_lane_q <= wstrb_i[0];
		end else if (do_wr) begin
			w_hold_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_q <= 1'b0;
			bresp_q  <= `RESP_OKAY;
		end else if (do_wr) begin
			bvalid_q <= 1'b1;
			bresp_q  <= (wr_hit != 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bready_i) begin
			bvalid_q <= 1'b0;
		end
	end

	// ==========================================================
	// read channel
	logic        rvalid_q;
	logic [7:0]  rdata_q;
	logic [1:0]  rresp_q;
	logic [1:0]  rd_hit;
	logic [7:0]  rd_byte [2];

	assign arready_o = !rvalid_q;
	assign rvalid_o  = rvalid_q;
	assign rdata_o   = {24'h000000, rdata_q};
	assign rresp_o   = rresp_q;

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 8'h00;
			rresp_q  <= `RESP_OKAY;
		end else if (arvalid_i && arready_o) begin
			rvalid_q <= 1'b1;
			if (rd_hit[0]) begin
				rdata_q <= rd_byte[0];
				rresp_q <= `RESP_OKAY;
			end else if (rd_hit[1]) begin
				rdata_q <= rd_byte[1];
				rresp_q <= `RESP_OKAY;
			end else begin
				rdata_q <= 8'h00;
				rresp_q <= `RESP_SLVERR;
			end
		end else if (rready_i) begin
			rvalid_q <= 1'b0;
		end
	end

	// ==========================================================
	// per-timer registers, pins and dead band
	timer_core_if cif [2] ();

	for (genvar g = 0; g < 2; g++) begin : gen_tmr
		localparam logic [8:0] GRP = (g == 0) ? `GRP_T0 : `GRP_T1;

		logic [15:0] reload_q;
		logic [15:0] match_q;
		logic [7:0]  ctl0_q;
		logic [7:0]  ctl1_q;
		logic [1:0]  sync_q;
		logic        wr_sel;
		logic        src_in;
		logic        src_rc;
		logic        evt;
		logic        evt_q;
		logic [3:0]  mode;
		logic        is_pwm;
		logic        is_dual;
		logic [7:0]  dly;
		logic        pwm_prev_q;
		logic [7:0]  db_cnt_q;
		logic        settled;
		logic        out_q;
		logic        comp_q;

		assign wr_hit[g] = (aw_addr_q[15:14] == 2'h0) && (aw_addr_q[13:5] == GRP);
		assign rd_hit[g] = (araddr_i[15:14] == 2'h0) && (araddr_i[13:5] == GRP);
		assign wr_sel    = wr_en && wr_hit[g];

		assign mode    = {ctl0_q[`CTL0_MODE_MSB], ctl1_q[`CTL1_MODE_HI:0]};
		assign is_pwm  = (mode == `MODE_PWM_SINGLE) || (mode == `MODE_PWM_DUAL);
		assign is_dual = (mode == `MODE_PWM_DUAL);

		assign cif[g].enable    = ctl1_q[`CTL1_RUN];
		assign cif[g].mode      = mode;
		assign cif[g].polarity  = ctl1_q[`CTL1_POL];
		assign cif[g].prescale  = ctl1_q[`CTL1_PRES_HI:`CTL1_PRES_LO];
		assign cif[g].reload    = reload_q;
		assign cif[g].match     = match_q;
		assign cif[g].in_sync   = sync_q[1];
		assign cif[g].cnt_wr    = wr_sel && ((wr_reg == `REG_CNT_H) || (wr_reg == `REG_CNT_L));
		assign cif[g].cnt_wdata = (wr_reg == `REG_CNT_H) ? {w_byte_q, cif[g].count[7:0]}
		                                                 : {cif[g].count[15:8], w_byte_q};

		timer_core u_core (
			.clk_i   (ref_clk_i),
			.rst_n_i (rst_n),
			.cif     (cif[g])
		);

		always_ff @(posedge ref_clk_i or negedge rst_n) begin
			if (!rst_n) begin
				sync_q <= 2'h0;
			end else begin
				sync_q <= {sync_q[0], tmr_in_i[g]};
			end
		end

		always_ff @(posedge ref_clk_i or negedge rst_n) begin
			if (!rst_n) begin
				reload_q <= {`REG_RESET, `REG_RESET};
			end else if (wr_sel && wr_reg == `REG_RLD_H) begin
				reload_q[15:8] <= w_byte_q;
			end else if (wr_sel && wr_reg == `REG_RLD_L) begin
				reload_q[7:0] <= w_byte_q;
			end
		end

		// a capture beats a software write in the same cycle
		always_ff @(posedge ref_clk_i or negedge rst_n) begin
			if (!rst_n) begin
				match_q <= {`REG_RESET, `REG_RESET};
			end else if (cif[g].capture_evt) begin
				match_q <= cif[g].count;
			end else if (wr_sel && wr_reg == `REG_MATCH_H) begin
				match_q[15:8] <= w_byte_q;
			end else if (wr_sel && wr_reg == `REG_MATCH_L) begin
				match_q[7:0] <= w_byte_q;
			end
		end

		// event source selection
		assign src_in = cif[g].capture_evt;
		assign src_rc = cif[g].reload_evt || cif[g].compare_evt;
		assign evt    = !ctl0_q[`CTL0_CFG_HI] ? (src_in || src_rc)
		              : (ctl0_q[`CTL0_CFG_LO] ? src_rc : src_in);

		always_ff @(posedge ref_clk_i or negedge rst_n) begin
			if (!rst_n) begin
				ctl0_q <= `REG_RESET;
			end else begin
				if (wr_sel && wr_reg == `REG_CTL0) begin
					ctl0_q <= w_byte_q & `CTL0_WMASK;
				end
				if (evt) begin
					// hardware update of the flag wins over a write
					ctl0_q[`CTL0_FLAG] <= src_in && (ctl0_q[`CTL0_CFG_HI:`CTL0_CFG_LO] != 2'h3);
				end
			end
		end

		always_ff @(posedge ref_clk_i or negedge rst_n) begin
			if (!rst_n) begin
				ctl1_q <= `REG_RESET;
			end else begin
				if (wr_sel && wr_reg == `REG_CTL1) begin
					ctl1_q <= w_byte_q;
				end
				if (cif[g].oneshot_done) begin
					ctl1_q[`CTL1_RUN] <= 1'b0;
				end
			end
		end

		always_ff @(posedge ref_clk_i or negedge rst_n) begin
			if (!rst_n) begin
				evt_q <= 1'b0;
			end else begin
				evt_q <= evt;
			end
		end
		assign tmr_event_o[g] = evt_q;

		// read mux
		always_comb begin
			if (araddr_i[4:2] == `REG_CNT_H) begin
				rd_byte[g] = cif[g].count[15:8];
			end else if (araddr_i[4:2] == `REG_CNT_L) begin
				rd_byte[g] = cif[g].count[7:0];
			end else if (araddr_i[4:2] == `REG_RLD_H) begin
				rd_byte[g] = reload_q[15:8];
			end else if (araddr_i[4:2] == `REG_RLD_L) begin
				rd_byte[g] = reload_q[7:0];
			end else if (araddr_i[4:2] == `REG_MATCH_H) begin
				rd_byte[g] = match_q[15:8];
			end else if (araddr_i[4:2] == `REG_MATCH_L) begin
				rd_byte[g] = match_q[7:0];
			end else if (araddr_i[4:2] == `REG_CTL0) begin
				rd_byte[g] = ctl0_q;
			end else begin
				rd_byte[g] = ctl1_q;
			end
		end

		// dead band: cycles since the pwm level last changed
		assign dly = (ctl0_q[`CTL0_DB_HI:`CTL0_DB_LO] == 3'h0) ? 8'h00
		           : (8'h01 << ctl0_q[`CTL0_DB_HI:`CTL0_DB_LO]);
		assign settled = (dly == 8'h00) || ((cif[g].pwm == pwm_prev_q) && (db_cnt_q >= dly));

		always_ff @(posedge ref_clk_i or negedge rst_n) begin
			if (!rst_n) begin
				pwm_prev_q <= 1'b0;
				db_cnt_q   <= 8'h00;
			end else begin
				pwm_prev_q <= cif[g].pwm;
				if (cif[g].pwm != pwm_prev_q) begin
					db_cnt_q <= 8'h01;
				end else if (db_cnt_q != `DB_CNT_MAX) begin
					db_cnt_q <= db_cnt_q + 8'h01;
				end
			end
		end

		// both outputs drop at once, each rises only after the gap
		always_ff @(posedge ref_clk_i or negedge rst_n) begin
			if (!rst_n) begin
				out_q  <= 1'b0;
				comp_q <= 1'b0;
			end else begin
				out_q  <= is_pwm && cif[g].pwm && settled;
				comp_q <= is_dual && !cif[g].pwm && settled;
			end
		end
		assign tmr_out_o[g]     = out_q;
		assign tmr_comp_o[g]    = comp_q;
		assign tmr_comp_oe_o[g] = is_dual;

		AST_COMP_PIN_DUAL: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
			tmr_comp_oe_o[g] == (ctl0_q[7] && ctl1_q[2:0] == 3'h0))
			else $error("complement pin ownership wrong");
		AST_NO_OVERLAP: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
			!(out_q && comp_q))
			else $error("output and complement both active");
		AST_DB_GAP: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
			$rose(out_q) && dly == 8'h02 && $stable(dly) |-> $past(cif[g].pwm, 3))
			else $error("output rose before dead band ran out");
		AST_CAPTURE_STORED: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
			cif[g].capture_evt |=> match_q == $past(cif[g].count))
			else $error("captured count not stored in match");
		AST_CFG_INPUT_ONLY: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
			ctl0_q[6:5] == 2'h2 && src_rc && !src_in |=> !tmr_event_o[g])
			else $error("reload or compare event leaked with input-only config");
		AST_FLAG_SOURCE: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
			tmr_event_o[g] |-> ctl0_q[0] == $past(src_in && ctl0_q[6:5] != 2'h3))
			else $error("capture flag does not match last event");

		COV_DUAL_RUN: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
			is_dual && $rose(comp_q));
		COV_WRITE_DONE: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
			wr_sel && wr_reg == `REG_CTL1);
	end
endmodule

`default_nettype wire

// file: verification/tb_timer_pwm_capture_core.sv
// self-checking bench for the timer block over its register bus and pins
// assumes timer_params.svh on the include path
`include "timer_params.svh"
`default_nettype none

module tb_timer_pwm_capture_core;
	timeunit 1ns;
	timeprecision 1ns;
	// ====
	// signals
	logic        ref_clk = 0, resetn = 0;
	logic [15:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic [3:0]  wstrb = 4'hF;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rs, bs, tout, tcomp, toe, tev, tin, lvl = 2'b00;
	logic [7:0]  rq;
	logic [11:0] ids [4] = '{`IDX_T0_MATCH_L, `IDX_T0_CTL0, `IDX_T1_MATCH_L, `IDX_T1_CTL0};
	int          n_mismatch = 0, samples_checked = 0, cyc = 0, ev = 0, ovl, hi, per, m, r;

	always #50 ref_clk = ~ref_clk;

	timer_pwm_capture_core i_dut (.ref_clk_i(ref_clk), .resetn_i(resetn),
		.awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready),
		.wdata_i(wdata), .wstrb_i(wstrb), .wvalid_i(wvalid), .wready_o(wready),
		.bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
		.araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready),
		.rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready),
		.tmr_out_o(tout), .tmr_in_i(tin), .tmr_comp_o(tcomp),
		.tmr_comp_oe_o(toe), .tmr_event_o(tev));

	tmr_pin_model i_pins (.clk_i(ref_clk), .lvl_i(lvl), .out_i(tout), .comp_i(tcomp),
		.comp_oe_i(toe), .pin_o(tin), .overlap_o(ovl));

	// sampled on the falling edge so clearing ev never races the count
	always @(negedge ref_clk) if (tev[0] === 1'b1) ev++;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	// ====
	// tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	function automatic logic [15:0] ia(input logic [11:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction

	function automatic logic [15:0] ra(input logic [2:0] x);
		return ia({`GRP_T0, x});
	endfunction

	// bready and rready stay up between transfers; only the bench timeout ends a wait
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bs = bresp;
	endtask

	task automatic rd(input logic [15:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rq = rdata[7:0];
		rs = rresp;
	endtask

	// software order: mode and polarity, count, match, dead band, reload, run last
	task automatic setup(input logic [7:0] c0, input logic [7:0] c1, input logic [15:0] mv,
		input logic [15:0] rv);
		wr(ra(`REG_CTL1), c1 & 8'h7F);
		wr(ra(`REG_CNT_H), 8'h00);
		wr(ra(`REG_CNT_L), 8'h01);
		wr(ra(`REG_MATCH_H), mv[15:8]);
		wr(ra(`REG_MATCH_L), mv[7:0]);
		wr(ra(`REG_CTL0), c0);
		wr(ra(`REG_RLD_H), rv[15:8]);
		wr(ra(`REG_RLD_L), rv[7:0]);
		wr(ra(`REG_CTL1), c1);
	endtask

	function automatic logic pv(input bit c);
		return c ? tcomp[0] : tout[0];
	endfunction

	task automatic wt(input bit c, input logic v, inout int n);
		while (pv(c) === v && n < 900) begin
			@(posedge ref_clk);
			n++;
		end
	endtask

	// high time and period of one output, from a rising edge on
	task automatic meas(input bit c);
		int t;
		t = 0;
		hi = 0;
		wt(c, 1'b1, t);
		wt(c, 1'b0, t);
		wt(c, 1'b1, hi);
		per = hi;
		wt(c, 1'b0, per);
	endtask

	// ====
	// main sequence
	initial begin
		void'($urandom(32'h4f63));
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		foreach (ids[i]) begin
			rd(ia(ids[i]));
			chk("reset value", rq, `REG_RESET);
			chk("read resp", rs, `RESP_OKAY);
		end
		rd(16'h0000);
		chk("unmapped resp", rs, `RESP_SLVERR);
		wr(16'h0000, 8'h00);
		chk("unmapped bresp", bs, `RESP_SLVERR);
		// lane 0 strobe low: answered, but nothing stored
		wstrb <= 4'hE;
		wr(ia(`IDX_T1_MATCH_L), 8'h5A);
		wstrb <= 4'hF;
		chk("strobe off bresp", bs, `RESP_OKAY);
		rd(ia(`IDX_T1_MATCH_L));
		chk("strobe off", rq, `REG_RESET);
		wr(ia(`IDX_T1_CTL0), 8'hFF);
		rd(ia(`IDX_T1_CTL0));
		chk("ctl0 mask", rq, `CTL0_WMASK);
		chk("t1 comp oe", toe[1], 1'b1);
		wr(ia(`IDX_T1_CTL0), 8'h00);
		$display("test registers done");
		for (int p = 0; p < 2; p++) begin
			m = 2 + $urandom % 5;
			// reload above match, both phases longer than any dead band used
			r = m + 3 + $urandom % 5;
			setup(p ? 8'h40 : 8'h60, 8'h8B | 8'(p << 6), 16'(m), 16'(r));
			meas(0);
			meas(0);
			chk("period", per, 2 * r);
			chk("high time", hi, p ? 2 * m : 2 * (r - m));
			ev = 0;
			repeat (4 * r) @(posedge ref_clk);
			chk("events", ev, p ? 0 : 4);
			chk("single oe", toe[0], 1'b0);
		end
		$display("test pwm done");
		setup(8'h82, 8'h88, 16'(m), 16'(r));
		meas(0);
		meas(0);
		chk("dual high", hi, 2 * (r - m) - 2);
		chk("dual period", per, 2 * r);
		meas(1);
		meas(1);
		chk("comp high", hi, 2 * m - 2);
		chk("overlap", ovl, 0);
		chk("dual oe", toe[0], 1'b1);
		$display("test dual done");
		for (int p = 0; p < 2; p++) begin
			lvl[0] <= ~p[0];
			// second pass runs in capture/compare mode
			setup(8'h40, 8'h84 | 8'(p << 6) | 8'(3 * p), 16'h0000, 16'hFFFF);
			ev = 0;
			lvl[0] <= p[0];
			repeat (10) @(posedge ref_clk);
			chk("wrong edge", ev, 0);
			lvl[0] <= ~p[0];
			repeat (10) @(posedge ref_clk);
			chk("capture event", ev, 1);
			rd(ra(`REG_CTL0));
			chk("capture flag", rq[0], 1'b1);
			// count is 2 when setup returns, +1 per cycle; pin seen 2 edges after change
			rd(ra(`REG_MATCH_L));
			chk("captured low", rq, 8'h0E);
			rd(ra(`REG_MATCH_H));
			chk("captured high", rq, 8'h00);
		end
		$display("test capture done");
		// one-shot: runs 1 to reload once, then stops; flag preset by software
		setup(8'h01, 8'h80, 16'h0000, 16'h0005);
		ev = 0;
		repeat (20) @(posedge ref_clk);
		chk("one-shot events", ev, 1);
		rd(ra(`REG_CTL1));
		chk("one-shot stop", rq[7], 1'b0);
		rd(ra(`REG_CTL0));
		chk("one-shot flag", rq[0], 1'b0);
		rd(ra(`REG_CNT_L));
		chk("one-shot count", rq, 8'h01);
		chk("t1 idle", {tout[1], tcomp[1], tev[1]}, 3'b000);
		$display("test one-shot done");
		wrap_up();
	end
endmodule

`default_nettype wire

// file: verification/tmr_pin_model.sv
// external circuit on the timer pins: input level source, output watcher
// assumes the bench picks the level it wants on each timer input pin
`default_nettype none

// ====
// pin model
module tmr_pin_model (
	// clock
	input  wire logic       clk_i,
	// bench side
	input  wire logic [1:0] lvl_i,
	// timer side
	input  wire logic [1:0] out_i,
	input  wire logic [1:0] comp_i,
	input  wire logic [1:0] comp_oe_i,
	output logic [1:0]      pin_o,
	output int              overlap_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// our driver lets go while the complement output owns the shared pin
	assign pin_o = (comp_oe_i & comp_i) | (~comp_oe_i & lvl_i);
	initial overlap_o = 0;
	always @(negedge clk_i) begin
		if ((out_i & comp_i) !== 2'b00)
			overlap_o++;
	end
endmodule

`default_nettype wire
